//--- hw/sfre_pkg.sv
/*
 Shared constants, types and decode helpers for the serial flash read and
 erase engine. Assumes a 100 MHz system clock and a 24-bit serial address.
*/
package sfre_pkg;

	////////////////////////////////////////////////////////////////////////
	// Command codes
	localparam logic [7:0] OPC_PLAIN_READ = 8'h03;
	localparam logic [7:0] OPC_FAST_READ = 8'h0b;
	localparam logic [7:0] OPC_DUAL_OUTPUT_FETCH = 8'h3b;
	localparam logic [7:0] OPC_DUAL_IO_FETCH = 8'hbb;
	localparam logic [7:0] OPC_QUAD_OUTPUT_FETCH = 8'h6b;
	localparam logic [7:0] OPC_QUAD_IO_FETCH = 8'heb;
	localparam logic [7:0] OPC_SMALL_UNIT_WIPE_CMD = 8'h20;
	localparam logic [7:0] OPC_HALF_BLOCK_WIPE_CMD = 8'h52;
	localparam logic [7:0] OPC_WRITE_UNLOCK_CMD = 8'h06;
	localparam logic [7:0] OPC_STATUS_READ = 8'h05;

	////////////////////////////////////////////////////////////////////////
	// Framing and layout
	localparam int ADDR_BITS = 24;
	localparam logic [4:0] OPC_LAST_BIT = 5'h07;
	localparam int SECTOR_LSB = 12;
	localparam int BLOCK_LSB = 15;
	localparam int ARRAY_AW_DEF = 18;
	localparam logic [15:0] SECTOR_BYTES = 16'h1000;
	localparam logic [15:0] HALF_BLOCK_BYTES = 16'h8000;
	localparam logic [7:0] WIPE_VALUE = 8'hff;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	localparam logic [2:0] LANE_1 = 3'h1;
	localparam logic [2:0] LANE_2 = 3'h2;
	localparam logic [2:0] LANE_4 = 3'h4;

	localparam logic [3:0] DUMMY_NONE = 4'h0;
	localparam logic [3:0] DUMMY_FAST = 4'h8;
	localparam logic [3:0] DUMMY_DUAL_OUT = 4'h8;
	localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
	localparam logic [3:0] DUMMY_QUAD_OUT = 4'h8;
	localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;

	// Status byte fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_LATCH_BIT = 1;
	localparam int STAT_PROT_LSB = 2;
	localparam int STAT_QUAD_BIT = 6;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_PS = 10000;
	localparam int SMALL_UNIT_WIPE_TIME_US = 50;
	localparam int HALF_BLOCK_WIPE_TIME_US = 400;
	localparam int SMALL_UNIT_WIPE_CYCLES_DEF = (SMALL_UNIT_WIPE_TIME_US * 1000000) / CLK_PERIOD_PS;
	localparam int HALF_BLOCK_WIPE_CYCLES_DEF = (HALF_BLOCK_WIPE_TIME_US * 1000000) / CLK_PERIOD_PS;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_OPC = 8'h02,
		ST_ADDR = 8'h04,
		ST_DUMMY = 8'h08,
		ST_DATA = 8'h10,
		ST_STAT = 8'h20,
		ST_TAIL = 8'h40,
		ST_SKIP = 8'h80
	} sfre_state_e;

	typedef struct packed {
		logic sclk;
		logic cs_n;
		logic [3:0] io;
	} sfre_pins_s;

	typedef struct packed {
		logic known;
		logic is_read;
		logic is_wipe;
		logic is_unlock;
		logic is_status;
		logic needs_quad;
		logic half_block;
		logic [2:0] alanes;
		logic [2:0] dlanes;
		logic [3:0] dummy;
	} sfre_cmd_s;

	function automatic sfre_cmd_s sfre_decode(input logic [7:0] op);
		sfre_cmd_s c;
		c = '0;
		c.known = 1'b1;
		c.alanes = LANE_1;
		c.dlanes = LANE_1;
		c.dummy = DUMMY_NONE;
		case (op)
			OPC_PLAIN_READ: c.is_read = 1'b1;
			OPC_FAST_READ:
			begin
				c.is_read = 1'b1;
				c.dummy = DUMMY_FAST;
			end
			OPC_DUAL_OUTPUT_FETCH:
			begin
				c.is_read = 1'b1;
				c.dlanes = LANE_2;
				c.dummy = DUMMY_DUAL_OUT;
			end
			OPC_DUAL_IO_FETCH:
			begin
				c.is_read = 1'b1;
				c.alanes = LANE_2;
				c.dlanes = LANE_2;
				c.dummy = DUMMY_DUAL_IO;
			end
			OPC_QUAD_OUTPUT_FETCH:
			begin
				c.is_read = 1'b1;
				c.needs_quad = 1'b1;
				c.dlanes = LANE_4;
				c.dummy = DUMMY_QUAD_OUT;
			end
			OPC_QUAD_IO_FETCH:
			begin
				c.is_read = 1'b1;
				c.needs_quad = 1'b1;
				c.alanes = LANE_4;
				c.dlanes = LANE_4;
				c.dummy = DUMMY_QUAD_IO;
			end
			OPC_SMALL_UNIT_WIPE_CMD: c.is_wipe = 1'b1;
			OPC_HALF_BLOCK_WIPE_CMD:
			begin
				c.is_wipe = 1'b1;
				c.half_block = 1'b1;
			end
			OPC_WRITE_UNLOCK_CMD: c.is_unlock = 1'b1;
			OPC_STATUS_READ: c.is_status = 1'b1;
			default: c.known = 1'b0;
		endcase
		return c;
	endfunction

	// Serial clocks taken by the 24-bit address at a given lane count
	function automatic logic [4:0] sfre_addr_clocks(input logic [2:0] lanes);
		return 5'(ADDR_BITS / int'(lanes));
	endfunction

endpackage

//--- hw/sfre_pin_sync.sv
/*
 Two-flop synchroniser for the link pins plus one extra stage for edge
 finding. Assumes pins are asynchronous to clk_in.
*/
`timescale 1ns/1ps
module sfre_pin_sync #(
	parameter int W = 6
)(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level_out,
	output logic [W-1:0] prev_out
);
	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;
	logic [W-1:0] prev_q;
	logic [W-1:0] prev_d;

	// First stage feeds only the second stage
	always_comb
	begin
		meta_d = async_in;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			meta_q <= '1;
			sync_q <= '1;
			prev_q <= '1;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign level_out = sync_q;
	assign prev_out = prev_q;
endmodule

//--- hw/sfre_engine.sv
/*
 Device-side serial flash engine: array reads in 1/2/4-lane modes, sector
 and half-block erase with self-timed busy, write latch and protection.
 Assumes a host drives chip select and serial clock well below clk_in / 8.
*/
`timescale 1ns/1ps
module sfre_engine #(
	parameter int ARRAY_AW = sfre_pkg::ARRAY_AW_DEF,
	parameter int SMALL_UNIT_WIPE_CYCLES = sfre_pkg::SMALL_UNIT_WIPE_CYCLES_DEF,
	parameter int HALF_BLOCK_WIPE_CYCLES = sfre_pkg::HALF_BLOCK_WIPE_CYCLES_DEF
)(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic serial_clk_in,
	input wire logic chip_sel_n_in,
	input wire logic [3:0] io_line_in,
	input wire logic quad_allow_bit_in,
	input wire logic [3:0] protect_level_bits_in,
	output logic [3:0] io_line_out,
	output logic [3:0] io_line_oe_out,
	output logic busy_flag_out,
	output logic write_latch_flag_out
);
	import sfre_pkg::*;

	if (ARRAY_AW < BLOCK_LSB || ARRAY_AW > ADDR_BITS)
	begin : g_bad_aw
		$error("array address width out of range");
	end
	if (SMALL_UNIT_WIPE_CYCLES < int'(SECTOR_BYTES) || HALF_BLOCK_WIPE_CYCLES < int'(HALF_BLOCK_BYTES))
	begin : g_bad_time
		$error("wipe time shorter than one byte per cycle");
	end

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and edges
	sfre_pins_s pins_now;
	sfre_pins_s pins_prev;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_rise;

	sfre_pin_sync #(
		.W(6)
	) u_sync (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.async_in({serial_clk_in, chip_sel_n_in, io_line_in}),
		.level_out(pins_now),
		.prev_out(pins_prev)
	);

	assign sclk_rise = pins_now.sclk & ~pins_prev.sclk;
	assign sclk_fall = ~pins_now.sclk & pins_prev.sclk;
	assign cs_rise = pins_now.cs_n & ~pins_prev.cs_n;

	////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [ARRAY_AW-1:0] shift_in(input logic [ARRAY_AW-1:0] a, input logic [3:0] io,
		input logic [2:0] lanes);
		logic [ARRAY_AW-1:0] r;
		r = a;
		case (lanes)
			LANE_2: r = {a[ARRAY_AW-3:0], io[1:0]};
			LANE_4: r = {a[ARRAY_AW-5:0], io};
			default: r = {a[ARRAY_AW-2:0], io[0]};
		endcase
		return r;
	endfunction

	function automatic logic [3:0] lane_mask(input logic [2:0] lanes);
		logic [3:0] m;
		case (lanes)
			LANE_2: m = 4'h3;
			LANE_4: m = 4'hf;
			default: m = 4'h2;
		endcase
		return m;
	endfunction

	function automatic logic [3:0] lane_bits(input logic [7:0] b, input logic [2:0] lanes);
		logic [3:0] v;
		case (lanes)
			LANE_2: v = {2'h0, b[7:6]};
			LANE_4: v = b[7:4];
			default: v = {2'h0, b[7], 1'b0};
		endcase
		return v;
	endfunction

	// Protected region grows downward from the top sector
	function automatic logic is_protected(input logic [ARRAY_AW-1:0] a, input logic [3:0] bp, input logic half);
		int nsect;
		int cnt;
		int idx;
		nsect = 1 << (ARRAY_AW - SECTOR_LSB);
		cnt = 0;
		idx = int'(a >> SECTOR_LSB);
		if (half)
			idx = idx | ((1 << (BLOCK_LSB - SECTOR_LSB)) - 1);
		if (bp != 4'h0)
			cnt = (int'(bp) - 1 >= ARRAY_AW - SECTOR_LSB) ? nsect : (1 << (int'(bp) - 1));
		return (bp != 4'h0) && (idx >= nsect - cnt);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Frame state
	sfre_state_e state_q, state_d;
	logic [4:0] cnt_q, cnt_d;
	logic [7:0] op_q, op_d;
	sfre_cmd_s cmd_q, cmd_d;
	logic [ARRAY_AW-1:0] addr_q, addr_d;
	logic [7:0] osh_q, osh_d;
	logic [3:0] ocnt_q, ocnt_d;
	logic [3:0] io_q, io_d;
	logic [3:0] oe_q, oe_d;
	logic wipe_go;
	logic unlock_go;
	sfre_cmd_s dec;
	logic [7:0] cur_byte;
	logic [7:0] status_byte;
	logic [2:0] out_lanes;
	logic [3:0] ocnt_sum;
	logic busy_q;
	logic wel_q;
	logic [7:0] array_q [0:(1 << ARRAY_AW)-1];

	always_comb
	begin
		status_byte = 8'h00;
		status_byte[STAT_BUSY_BIT] = busy_q;
		status_byte[STAT_LATCH_BIT] = wel_q;
		status_byte[STAT_PROT_LSB +: 4] = protect_level_bits_in;
		status_byte[STAT_QUAD_BIT] = quad_allow_bit_in;
	end

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		op_d = op_q;
		cmd_d = cmd_q;
		addr_d = addr_q;
		osh_d = osh_q;
		ocnt_d = ocnt_q;
		io_d = io_q;
		oe_d = oe_q;
		wipe_go = 1'b0;
		unlock_go = 1'b0;
		cur_byte = 8'h00;
		out_lanes = LANE_1;
		ocnt_sum = 4'h0;
		dec = sfre_decode({op_q[6:0], pins_now.io[0]});
		if (cs_rise)
		begin
			// Only a frame that stopped exactly after the last bit counts
			if (state_q == ST_TAIL)
			begin
				wipe_go = cmd_q.is_wipe;
				unlock_go = cmd_q.is_unlock;
			end
			state_d = ST_IDLE;
			oe_d = 4'h0;
		end
		else if (state_q == ST_IDLE)
		begin
			if (!pins_now.cs_n)
			begin
				state_d = ST_OPC;
				cnt_d = 5'h00;
				ocnt_d = 4'h0;
			end
		end
		else if (sclk_rise)
		begin
			case (state_q)
				ST_OPC:
				begin
					op_d = {op_q[6:0], pins_now.io[0]};
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == OPC_LAST_BIT)
					begin
						cmd_d = dec;
						cnt_d = 5'h00;
						if (!dec.known || (dec.needs_quad && !quad_allow_bit_in))
							state_d = ST_SKIP;
						else if (busy_q && !dec.is_status)
							state_d = ST_SKIP;
						else if (dec.is_unlock)
							state_d = ST_TAIL;
						else if (dec.is_status)
							state_d = ST_STAT;
						else
							state_d = ST_ADDR;
					end
				end
				ST_ADDR:
				begin
					// Erase uses one lane, so lines 3..1 never reach the address
					addr_d = shift_in(addr_q, pins_now.io, cmd_q.alanes);
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == sfre_addr_clocks(cmd_q.alanes) - 5'h01)
					begin
						cnt_d = 5'h00;
						if (cmd_q.is_wipe)
							state_d = ST_TAIL;
						else if (cmd_q.dummy == DUMMY_NONE)
							state_d = ST_DATA;
						else
							state_d = ST_DUMMY;
					end
				end
				ST_DUMMY:
				begin
					// Lines stay undriven here; host owns them
					cnt_d = cnt_q + 5'h01;
					if (cnt_q == {1'b0, cmd_q.dummy} - 5'h01)
						state_d = ST_DATA;
				end
				ST_TAIL: state_d = ST_SKIP;
				default:
				begin
				end
			endcase
		end
		else if (sclk_fall && (state_q == ST_DATA || state_q == ST_STAT))
		begin
			out_lanes = (state_q == ST_STAT) ? LANE_1 : cmd_q.dlanes;
			if (ocnt_q == 4'h0)
				cur_byte = (state_q == ST_STAT) ? status_byte : array_q[addr_q];
			else
				cur_byte = osh_q;
			io_d = lane_bits(cur_byte, out_lanes);
			oe_d = lane_mask(out_lanes);
			osh_d = cur_byte << out_lanes;
			ocnt_sum = ocnt_q + {1'b0, out_lanes};
			ocnt_d = ocnt_sum;
			if (ocnt_sum == BYTE_BITS)
			begin
				ocnt_d = 4'h0;
				if (state_q == ST_DATA)
					addr_d = addr_q + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			state_q <= ST_IDLE;
			cnt_q <= 5'h00;
			op_q <= 8'h00;
			cmd_q <= '0;
			addr_q <= '0;
			osh_q <= 8'h00;
			ocnt_q <= 4'h0;
			io_q <= 4'h0;
			oe_q <= 4'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			op_q <= op_d;
			cmd_q <= cmd_d;
			addr_q <= addr_d;
			osh_q <= osh_d;
			ocnt_q <= ocnt_d;
			io_q <= io_d;
			oe_q <= oe_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Self-timed erase
	logic busy_d;
	logic wel_d;
	logic [31:0] cyc_q, cyc_d;
	logic [15:0] ptr_q, ptr_d;
	logic [ARRAY_AW-1:0] base_q, base_d;
	logic half_q, half_d;
	logic prot_q, prot_d;
	logic wr_en;
	logic [ARRAY_AW-1:0] wr_addr;
	logic [31:0] lim;

	assign lim = half_q ? 32'(HALF_BLOCK_WIPE_CYCLES) : 32'(SMALL_UNIT_WIPE_CYCLES);

	always_comb
	begin
		busy_d = busy_q;
		wel_d = wel_q;
		cyc_d = cyc_q;
		ptr_d = ptr_q;
		base_d = base_q;
		half_d = half_q;
		prot_d = prot_q;
		wr_en = 1'b0;
		wr_addr = base_q | ARRAY_AW'(ptr_q);
		if (busy_q)
		begin
			cyc_d = cyc_q + 32'h1;
			// One byte per cycle; whole unit done no later than the timer ends
			if (ptr_q != (half_q ? HALF_BLOCK_BYTES : SECTOR_BYTES))
			begin
				wr_en = !prot_q;
				ptr_d = ptr_q + 16'h1;
			end
			if (cyc_q == lim - 32'h1)
			begin
				busy_d = 1'b0;
				wel_d = 1'b0;
			end
		end
		else if (wipe_go && wel_q)
		begin
			busy_d = 1'b1;
			cyc_d = 32'h0;
			ptr_d = 16'h0;
			half_d = cmd_q.half_block;
			if (cmd_q.half_block)
				base_d = (addr_q >> BLOCK_LSB) << BLOCK_LSB;
			else
				base_d = (addr_q >> SECTOR_LSB) << SECTOR_LSB;
			prot_d = is_protected(addr_q, protect_level_bits_in, cmd_q.half_block);
		end
		else if (unlock_go)
			wel_d = 1'b1;
	end

	always_ff @(posedge clk_in or negedge reset_n_in)
	begin
		if (!reset_n_in)
		begin
			busy_q <= 1'b0;
			wel_q <= 1'b0;
			cyc_q <= 32'h0;
			ptr_q <= 16'h0;
			base_q <= '0;
			half_q <= 1'b0;
			prot_q <= 1'b0;
		end
		else
		begin
			busy_q <= busy_d;
			wel_q <= wel_d;
			cyc_q <= cyc_d;
			ptr_q <= ptr_d;
			base_q <= base_d;
			half_q <= half_d;
			prot_q <= prot_d;
		end
	end

	// Array has no reset; contents are unknown until erased
	always_ff @(posedge clk_in)
	begin
		if (wr_en)
			array_q[wr_addr] <= WIPE_VALUE;
	end

	assign io_line_out = io_q;
	assign io_line_oe_out = oe_q;
	assign busy_flag_out = busy_q;
	assign write_latch_flag_out = wel_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!reset_n_in);

	a_cs_release: assert property (cs_rise |=> (oe_q == 4'h0) && (state_q == ST_IDLE))
		else $error("lines not released after chip select rise");
	a_single_lane: assert property (sclk_fall && state_q == ST_DATA && cmd_q.dlanes == LANE_1
		|=> oe_q == 4'h2 && io_q[1] === $past(ocnt_q == 4'h0 ? array_q[addr_q][7] : osh_q[7]))
		else $error("single read bit not on line 1");
	a_busy_reject: assert property (sclk_rise && state_q == ST_OPC && cnt_q == OPC_LAST_BIT && busy_q
		&& dec.is_read |=> state_q == ST_SKIP)
		else $error("read accepted while busy");
	a_quad_gate: assert property (sclk_rise && state_q == ST_OPC && cnt_q == OPC_LAST_BIT
		&& dec.needs_quad && !quad_allow_bit_in |=> state_q == ST_SKIP ##1 oe_q == 4'h0)
		else $error("quad command taken without quad enable");
	a_addr_step: assert property (sclk_fall && state_q == ST_DATA
		&& (ocnt_q + {1'b0, cmd_q.dlanes}) == BYTE_BITS |=> addr_q == ARRAY_AW'($past(addr_q) + 1'b1))
		else $error("address did not step after byte");
	a_wipe_launch: assert property (wipe_go && wel_q && !busy_q |=> busy_q && cyc_q == 32'h0 ##1 busy_q)
		else $error("erase did not start");
	a_wipe_nolatch: assert property (wipe_go && !wel_q && !busy_q |=> !busy_q && !wel_q)
		else $error("erase ran without write latch");
	a_wipe_finish: assert property (busy_q && cyc_q == lim - 32'h1 |=> !busy_q && !wel_q)
		else $error("busy or latch not cleared at erase end");
	a_tail_discard: assert property (sclk_rise && state_q == ST_TAIL && !cs_rise
		|=> state_q == ST_SKIP ##1 !wipe_go)
		else $error("erase not discarded after extra clock");
	a_prot_write: assert property (busy_q && prot_q |-> !wr_en)
		else $error("protected area written");
	a_dummy_len: assert property (state_q == ST_DUMMY && sclk_rise && cnt_q == {1'b0, cmd_q.dummy} - 5'h01
		|=> state_q == ST_DATA && oe_q == 4'h0)
		else $error("dummy phase length wrong");
endmodule

//--- bench/sfre_host_model.sv
/*
 Host-side serial flash controller model: frames commands on the link.
 Assumes the bench clock drives clk_in; one serial clock spans 16 of its cycles.
*/
`timescale 1ns/1ps
module sfre_host_model (
	input wire logic clk_in,
	input wire logic [3:0] io_in,
	input wire logic [3:0] dut_oe_in,
	output sfre_pkg::sfre_pins_s pins_out,
	output logic [3:0] io_oe_out
);
	import sfre_pkg::*;

	logic [7:0] rx[$];
	logic saw_oe;
	logic [7:0] sh;

	initial
	begin
		pins_out = '{sclk: 1'b0, cs_n: 1'b1, io: 4'h0};
		io_oe_out = 4'h0;
		saw_oe = 1'b0;
	end

	always @(posedge clk_in)
		if (!pins_out.cs_n && dut_oe_in != 4'h0)
			saw_oe <= 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Drive on the low phase, sample just before the rise
	task automatic tick(input logic [3:0] d, input logic [3:0] oe, input logic [2:0] ln);
		pins_out.sclk = 1'b0;
		pins_out.io = d;
		io_oe_out = oe;
		repeat (8) @(negedge clk_in);
		case (ln)
			LANE_1: sh = {sh[6:0], io_in[1]};
			LANE_2: sh = {sh[5:0], io_in[1:0]};
			default: sh = {sh[3:0], io_in};
		endcase
		pins_out.sclk = 1'b1;
		repeat (8) @(negedge clk_in);
	endtask

	task automatic frame(input logic [7:0] op, input logic [2:0] al, input logic [23:0] a,
		input int nab, input int nd, input logic [2:0] dl, input int nby);
		logic [31:0] s;
		logic [3:0] m;
		s = {op, a};
		rx.delete();
		saw_oe = 1'b0;
		@(negedge clk_in);
		pins_out.cs_n = 1'b0;
		repeat (8) @(negedge clk_in);
		for (int i = 0; i < 8; i++)
		begin
			tick({3'h0, s[31]}, 4'h1, LANE_1);
			s = s << 1;
		end
		m = (al == LANE_1) ? 4'h1 : (al == LANE_2) ? 4'h3 : 4'hf;
		for (int i = 0; i < nab; i += int'(al))
		begin
			tick(4'(s[31:28] >> (4 - int'(al))), m, LANE_1);
			s = s << al;
		end
		// Dual-I/O holds lines 1 and 0 at zero early in the dummy phase
		for (int i = 0; i < nd; i++)
			tick(4'h0, (op == OPC_DUAL_IO_FETCH && i < 2) ? 4'h3 : 4'h0, LANE_1);
		for (int b = 0; b < nby; b++)
		begin
			for (int i = 0; i < 8; i += int'(dl))
				tick(4'h0, 4'h0, dl);
			rx.push_back(sh);
		end
		// Chip select rises while the serial clock is still high
		pins_out.cs_n = 1'b1;
		io_oe_out = 4'h0;
		repeat (8) @(negedge clk_in);
		pins_out.sclk = 1'b0;
		repeat (8) @(negedge clk_in);
	endtask
endmodule

//--- bench/tb.sv
/*
 Self-checking bench for the flash read and erase engine with a host model.
 Assumes short wipe timers and a 32K array so the run stays brief.
*/
`timescale 1ns/1ps
module tb;
	import sfre_pkg::*;

	localparam int AW = 15;
	localparam int SW = 4096;
	localparam int HW = 32768;

	logic clk_in;
	logic reset_n_in;
	logic quad;
	logic [3:0] prot;
	logic [3:0] io_line;
	logic [3:0] float_q;
	logic [3:0] dut_out;
	logic [3:0] dut_oe;
	logic [3:0] host_oe;
	logic busy;
	logic latch;
	logic latch_at_end;
	logic all_wiped;
	sfre_pins_s pins;
	int num_errors;
	int total_checks;
	int busy_run;
	int busy_len;
	logic [23:0] a;
	logic [7:0] ops [6] = '{OPC_PLAIN_READ, OPC_FAST_READ, OPC_DUAL_OUTPUT_FETCH, OPC_DUAL_IO_FETCH,
		OPC_QUAD_OUTPUT_FETCH, OPC_QUAD_IO_FETCH};
	logic [2:0] als [6] = '{LANE_1, LANE_1, LANE_1, LANE_2, LANE_1, LANE_4};
	logic [2:0] dls [6] = '{LANE_1, LANE_1, LANE_2, LANE_2, LANE_4, LANE_4};
	int dms [6] = '{0, 8, 8, 4, 8, 6};

	sfre_engine #(.ARRAY_AW(AW), .SMALL_UNIT_WIPE_CYCLES(SW), .HALF_BLOCK_WIPE_CYCLES(HW)) i_dut (
		.clk_in(clk_in), .reset_n_in(reset_n_in), .serial_clk_in(pins.sclk), .chip_sel_n_in(pins.cs_n),
		.io_line_in(io_line), .quad_allow_bit_in(quad), .protect_level_bits_in(prot), .io_line_out(dut_out),
		.io_line_oe_out(dut_oe), .busy_flag_out(busy), .write_latch_flag_out(latch));

	sfre_host_model i_host (.clk_in(clk_in), .io_in(io_line), .dut_oe_in(dut_oe), .pins_out(pins),
		.io_oe_out(host_oe));

	// Undriven lines toggle so a stale level never looks valid
	always_comb
		for (int i = 0; i < 4; i++)
			io_line[i] = dut_oe[i] ? dut_out[i] : host_oe[i] ? pins.io[i] : float_q[i];

	always @(posedge clk_in)
	begin
		float_q <= ~float_q;
		if (busy)
			busy_run <= busy_run + 1;
		else
		begin
			if (busy_run != 0)
			begin
				busy_len <= busy_run;
				latch_at_end <= latch;
			end
			busy_run <= 0;
		end
	end

	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic results();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	function automatic logic [7:0] stat(input logic l, input logic b);
		return {1'b0, quad, prot, l, b};
	endfunction

	// Unwritten array stays unknown; only wiped sectors read as ones
	function automatic logic [7:0] arr(input logic [23:0] x);
		return (all_wiped || x[14:12] == 3'h0) ? 8'hff : 8'hxx;
	endfunction

	task automatic wait_busy(input logic lvl, input int lim);
		int n;
		n = 0;
		while (busy !== lvl && n < lim)
		begin
			@(negedge clk_in);
			n++;
		end
		if (busy !== lvl)
		begin
			num_errors++;
			results();
		end
	endtask

	task automatic status(input logic [7:0] exp);
		i_host.frame(OPC_STATUS_READ, LANE_1, 24'h0, 0, 0, LANE_1, 1);
		check("status", 32'(i_host.rx[0]), 32'(exp));
	endtask

	task automatic unlock();
		i_host.frame(OPC_WRITE_UNLOCK_CMD, LANE_1, 24'h0, 0, 0, LANE_1, 0);
	endtask

	task automatic wipe(input logic [7:0] op, input logic [23:0] x, input int len);
		unlock();
		i_host.frame(op, LANE_1, x, 24, 0, LANE_1, 0);
		wait_busy(1'b1, 20);
		status(stat(1'b1, 1'b1));
		i_host.frame(OPC_FAST_READ, LANE_1, x, 24, 8, LANE_1, 1);
		check("busy read oe", 32'(i_host.saw_oe), 32'h0);
		check("busy kept", 32'(busy), 32'h1);
		wait_busy(1'b0, len + 50);
		// Run length is latched one clock after busy falls
		repeat (2) @(negedge clk_in);
		check("busy length", busy_len, len);
		check("latch at end", 32'(latch_at_end), 32'h0);
	endtask

	task automatic rd(input int k, input logic [23:0] x);
		i_host.frame(ops[k], als[k], x, 24, dms[k], dls[k], 4);
		if (k >= 4 && !quad)
			check("quad refused", 32'(i_host.saw_oe), 32'h0);
		else
			for (int j = 0; j < 4; j++)
				check("read data", 32'(i_host.rx[j]), 32'(arr(x + 24'(j))));
		check("released", 32'(dut_oe), 32'h0);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		reset_n_in = 1'b0;
		quad = 1'b0;
		prot = 4'h0;
		float_q = 4'h5;
		busy_run = 0;
		busy_len = 0;
		latch_at_end = 1'b0;
		all_wiped = 1'b0;
		num_errors = 0;
		total_checks = 0;
		a = 24'($urandom(68));
		repeat (2) @(negedge clk_in);
		reset_n_in = 1'b1;
		check("reset outs", {dut_oe, busy, latch}, 32'h0);
		repeat (4) @(negedge clk_in);
		status(stat(1'b0, 1'b0));
		wipe(OPC_SMALL_UNIT_WIPE_CMD, {9'($urandom), 3'h0, 12'($urandom)}, SW);
		i_host.frame(OPC_HALF_BLOCK_WIPE_CMD, LANE_1, 24'h0, 24, 0, LANE_1, 0);
		check("no latch wipe", 32'(busy), 32'h0);
		unlock();
		i_host.frame(OPC_HALF_BLOCK_WIPE_CMD, LANE_1, 24'h0, 24, 1, LANE_1, 0);
		check("late cs wipe", 32'(busy), 32'h0);
		status(stat(1'b1, 1'b0));
		prot = 4'h1;
		wipe(OPC_SMALL_UNIT_WIPE_CMD, {9'($urandom), 3'h7, 12'($urandom)}, SW);
		for (int q = 0; q < 2; q++)
		begin
			quad = q[0];
			for (int k = 0; k < 6; k++)
				rd(k, {9'($urandom), k[0] ? 3'h7 : 3'h0, 9'h1ff, 3'($urandom)});
		end
		prot = 4'h0;
		wipe(OPC_HALF_BLOCK_WIPE_CMD, 24'($urandom), HW);
		all_wiped = 1'b1;
		rd(5, {9'($urandom), 3'h7, 9'h1ff, 3'($urandom)});
		results();
	end
endmodule
